// File: src/acgc_consts.vh
`ifndef ACGC_CONSTS_VH
`define ACGC_CONSTS_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define ACGC_OFF_SCAN_INTERVAL   8'h00
`define ACGC_OFF_SAMPLE_INTERVAL 8'h04
`define ACGC_OFF_TOTAL_SCAN      8'h08
`define ACGC_OFF_SAMPLES_PER     8'h0c
`define ACGC_OFF_TRIG_DELAY      8'h10
`define ACGC_OFF_PRETRIG_SCAN    8'h14
`define ACGC_OFF_GP_VALUE        8'h18
`define ACGC_OFF_UNUSED_A        8'h1c
`define ACGC_OFF_GP_CONTROL      8'h20
`define ACGC_OFF_UNUSED_B        8'h2c

// ---------------------------------------------------------------
// Register widths
// ---------------------------------------------------------------
`define ACGC_W_SCAN_INTERVAL     24
`define ACGC_W_SAMPLE_INTERVAL   16
`define ACGC_W_TOTAL_SCAN        24
`define ACGC_W_SAMPLES_PER       9
`define ACGC_W_TRIG_DELAY        16
`define ACGC_W_PRETRIG_SCAN      16
`define ACGC_W_GP                16
`define ACGC_W_GP_CONTROL        8

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define ACGC_CTL_ENABLE_BIT      7
`define ACGC_CTL_SW_DIR_BIT      6
`define ACGC_CTL_DIR_SRC_BIT     5
`define ACGC_CTL_GATE_SRC_BIT    4
`define ACGC_CTL_CLK_SRC_BIT     3
`define ACGC_CTL_MODE_HI         1
`define ACGC_CTL_MODE_LO         0
`define ACGC_MODE_EVENT          2'h0
`define ACGC_MODE_PULSE          2'h1

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define ACGC_RST_COUNT           24'h000000
`define ACGC_RST_GP              16'h0000
`define ACGC_RST_SAMPLES_PER     9'h000
`define ACGC_RST_CONTROL         8'h00

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define ACGC_CORE_CLK_MHZ        100
`define ACGC_TIMEBASE_MHZ        10
`define ACGC_TIMEBASE_DIV        (`ACGC_CORE_CLK_MHZ / `ACGC_TIMEBASE_MHZ)

`endif

// File: src/acgc_pin_sync.v
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Pin synchroniser with agreement filter
// ---------------------------------------------------------------
// A new level is accepted only once the second and third stages agree,
// so a single metastable sample never reaches the counter.
module acgc_pin_sync
(
	// Clock and reset
	input  wire core_clk,
	input  wire reset,
	// Pin side
	input  wire pin_in,
	// Core side
	output reg  level_r,
	output wire rise
);

	reg stage1_r;
	reg stage2_r;
	reg stage3_r;
	reg level_nxt;

	always @*
	begin
		level_nxt = level_r;
		if (stage2_r == stage3_r)
			level_nxt = stage3_r;
	end

	assign rise = level_nxt & ~level_r;

	always @(posedge core_clk)
	begin
		if (reset)
		begin
			stage1_r <= 1'b0;
			stage2_r <= 1'b0;
			stage3_r <= 1'b0;
			level_r  <= 1'b0;
		end
		else
		begin
			stage1_r <= pin_in;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
			level_r  <= level_nxt;
		end
	end

endmodule

`default_nettype wire

// File: src/acgc_top.v
// How it works
// - Register accesses are full 32-bit words only.
// - Scan interval 24-bit, sample interval 16-bit registers.
// - Total scan count, 24 bits, read/write.
// - Samples per scan, 9 bits, read/write.
// - Trigger delay count, used in delay mode.
// - Pre-trigger scans, used in pre/middle modes.
// - One 16-bit general counter at 0x18.
// - Writing the count loads its start value.
// - Reading the count returns present value.
// - Control register is write only, reads zero.
// - Bit 7 enables the general counter.
// - Bit 6 chooses up or down in event mode; pulse mode always counts down.
// - Bit 5 picks pin or software direction.
// - Bit 4 picks pin gate or enable.
// - Bit 3 picks pin clock or timebase.
// - Bits 1:0 select event or pulse mode.
// - Counter result drives the output pin.
`timescale 1ns/1ps
`default_nettype none
`include "acgc_consts.vh"

module acgc_top
#(
	parameter TIMEBASE_DIV = `ACGC_TIMEBASE_DIV
)
(
	// Clock and reset
	input  wire        core_clk,
	input  wire        reset,
	// Register port
	input  wire [7:0]  reg_addr,
	input  wire [3:0]  reg_be,
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [31:0] reg_wdata,
	output reg  [31:0] reg_rdata,
	output reg         reg_rvalid,
	// Acquisition sequencer side
	input  wire        delay_trigger_mode,
	input  wire        pre_mid_trigger_mode,
	output wire [23:0] scan_interval_value,
	output wire [15:0] sample_interval_value,
	output wire [23:0] total_scan_value,
	output wire [8:0]  samples_per_scan_value,
	output wire [15:0] trigger_delay_value,
	output wire [15:0] pretrigger_scan_value,
	// Counter pins
	input  wire        ext_counter_clock_pin,
	input  wire        ext_counter_gate_pin,
	input  wire        ext_counter_direction_pin,
	output reg         counter_output_pin
);

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	function hit;
		input [7:0] addr;
		input [7:0] offset;
		begin
			hit = (addr == offset);
		end
	endfunction

	// Partial-width accesses are dropped whole, never merged.
	wire full_word = (reg_be == 4'hf);
	wire wr_ok     = reg_wr & full_word;
	wire rd_ok     = reg_rd & full_word;

	// ---------------------------------------------------------------
	// Acquisition timing registers
	// ---------------------------------------------------------------
	reg [`ACGC_W_SCAN_INTERVAL-1:0]   scan_interval_count_r;
	reg [`ACGC_W_SAMPLE_INTERVAL-1:0] sample_interval_count_r;
	reg [`ACGC_W_TOTAL_SCAN-1:0]      total_scan_count_r;
	reg [`ACGC_W_SAMPLES_PER-1:0]     samples_per_scan_count_r;
	reg [`ACGC_W_TRIG_DELAY-1:0]      trigger_delay_count_r;
	reg [`ACGC_W_PRETRIG_SCAN-1:0]    pretrigger_scan_count_r;
	reg [`ACGC_W_GP_CONTROL-1:0]      general_counter_control_r;

	always @(posedge core_clk)
	begin
		if (reset)
		begin
			scan_interval_count_r     <= `ACGC_RST_COUNT;
			sample_interval_count_r   <= `ACGC_RST_GP;
			total_scan_count_r        <= `ACGC_RST_COUNT;
			samples_per_scan_count_r  <= `ACGC_RST_SAMPLES_PER;
			trigger_delay_count_r     <= `ACGC_RST_GP;
			pretrigger_scan_count_r   <= `ACGC_RST_GP;
			general_counter_control_r <= `ACGC_RST_CONTROL;
		end
		else if (wr_ok)
		begin
			if (hit(reg_addr, `ACGC_OFF_SCAN_INTERVAL))
				scan_interval_count_r <= reg_wdata[23:0];
			if (hit(reg_addr, `ACGC_OFF_SAMPLE_INTERVAL))
				sample_interval_count_r <= reg_wdata[15:0];
			if (hit(reg_addr, `ACGC_OFF_TOTAL_SCAN))
				total_scan_count_r <= reg_wdata[23:0];
			if (hit(reg_addr, `ACGC_OFF_SAMPLES_PER))
				samples_per_scan_count_r <= reg_wdata[8:0];
			if (hit(reg_addr, `ACGC_OFF_TRIG_DELAY))
				trigger_delay_count_r <= reg_wdata[15:0];
			if (hit(reg_addr, `ACGC_OFF_PRETRIG_SCAN))
				pretrigger_scan_count_r <= reg_wdata[15:0];
			if (hit(reg_addr, `ACGC_OFF_GP_CONTROL))
				general_counter_control_r <= reg_wdata[7:0];
		end
	end

	assign scan_interval_value    = scan_interval_count_r;
	assign sample_interval_value  = sample_interval_count_r;
	assign total_scan_value       = total_scan_count_r;
	assign samples_per_scan_value = samples_per_scan_count_r;
	// The delay only reaches the sequencer in delay trigger mode.
	assign trigger_delay_value = delay_trigger_mode ?
		trigger_delay_count_r : 16'h0000;
	assign pretrigger_scan_value = pre_mid_trigger_mode ?
		pretrigger_scan_count_r : 16'h0000;

	// ---------------------------------------------------------------
	// Control fields
	// ---------------------------------------------------------------
	wire       ctl_enable  = general_counter_control_r[`ACGC_CTL_ENABLE_BIT];
	wire       sw_count_direction =
		general_counter_control_r[`ACGC_CTL_SW_DIR_BIT];
	wire       direction_source_select =
		general_counter_control_r[`ACGC_CTL_DIR_SRC_BIT];
	wire       gate_source_select =
		general_counter_control_r[`ACGC_CTL_GATE_SRC_BIT];
	wire       clock_source_select =
		general_counter_control_r[`ACGC_CTL_CLK_SRC_BIT];
	wire [1:0] counter_mode_select = general_counter_control_r[
		`ACGC_CTL_MODE_HI:`ACGC_CTL_MODE_LO];

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	wire [2:0] pin_raw;
	wire [2:0] pin_level;
	wire [2:0] pin_rise;

	assign pin_raw = {ext_counter_direction_pin, ext_counter_gate_pin,
		ext_counter_clock_pin};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1)
		begin : g_sync
			acgc_pin_sync u_sync
			(
				.core_clk (core_clk),
				.reset    (reset),
				.pin_in   (pin_raw[gi]),
				.level_r  (pin_level[gi]),
				.rise     (pin_rise[gi])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Internal timebase
	// ---------------------------------------------------------------
	localparam integer TB_LAST_INT = TIMEBASE_DIV - 1;
	localparam [15:0]  TB_LAST     = TB_LAST_INT[15:0];

	reg [15:0] timebase_cnt_r;
	wire       timebase_tick = (timebase_cnt_r == TB_LAST);

	always @(posedge core_clk)
	begin
		if (reset || timebase_tick)
			timebase_cnt_r <= 16'h0000;
		else
			timebase_cnt_r <= timebase_cnt_r + 16'h0001;
	end

	// ---------------------------------------------------------------
	// General counter
	// ---------------------------------------------------------------
	// The external clock counts on its rising edge after filtering, so
	// it must stay below a quarter of the core clock rate.
	wire count_edge = clock_source_select ?
		pin_rise[0] : timebase_tick;
	wire gate_open  = gate_source_select ?
		pin_level[1] : 1'b1;
	wire count_up   = direction_source_select ?
		pin_level[2] : sw_count_direction;
	wire step = ctl_enable & gate_open & count_edge;

	reg [`ACGC_W_GP-1:0] general_count_bits_r;
	reg [`ACGC_W_GP-1:0] general_count_bits_nxt;
	reg [`ACGC_W_GP-1:0] start_count_r;
	reg                  counter_output_nxt;

	wire gp_load = wr_ok & hit(reg_addr, `ACGC_OFF_GP_VALUE);

	always @*
	begin
		general_count_bits_nxt = general_count_bits_r;
		counter_output_nxt     = 1'b0;
		if (gp_load)
			general_count_bits_nxt = reg_wdata[15:0];
		else if (step)
		begin
			case (counter_mode_select)
				`ACGC_MODE_EVENT:
				begin
					if (count_up)
						general_count_bits_nxt =
							general_count_bits_r + 16'h0001;
					else
						general_count_bits_nxt =
							general_count_bits_r - 16'h0001;
					counter_output_nxt =
						(general_count_bits_nxt == 16'h0000);
				end
				`ACGC_MODE_PULSE:
				begin
					// Counts down to zero, pulses, and restarts from the
					// loaded value, giving a periodic pulse train.
					if (general_count_bits_r == 16'h0000)
					begin
						general_count_bits_nxt = start_count_r;
						counter_output_nxt     = 1'b1;
					end
					else
						general_count_bits_nxt =
							general_count_bits_r - 16'h0001;
				end
				default:
					general_count_bits_nxt = general_count_bits_r;
			endcase
		end
	end

	always @(posedge core_clk)
	begin
		if (reset)
		begin
			general_count_bits_r <= `ACGC_RST_GP;
			start_count_r        <= `ACGC_RST_GP;
			counter_output_pin   <= 1'b0;
		end
		else
		begin
			general_count_bits_r <= general_count_bits_nxt;
			counter_output_pin   <= counter_output_nxt;
			if (gp_load)
				start_count_r <= reg_wdata[15:0];
		end
	end

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	reg [31:0] rdata_nxt;

	always @*
	begin
		rdata_nxt = 32'h00000000;
		case (reg_addr)
			`ACGC_OFF_SCAN_INTERVAL:
				rdata_nxt = {8'h00, scan_interval_count_r};
			`ACGC_OFF_SAMPLE_INTERVAL:
				rdata_nxt = {16'h0000, sample_interval_count_r};
			`ACGC_OFF_TOTAL_SCAN:
				rdata_nxt = {8'h00, total_scan_count_r};
			`ACGC_OFF_SAMPLES_PER:
				rdata_nxt = {23'h000000, samples_per_scan_count_r};
			`ACGC_OFF_TRIG_DELAY:
				rdata_nxt = {16'h0000, trigger_delay_count_r};
			`ACGC_OFF_PRETRIG_SCAN:
				rdata_nxt = {16'h0000, pretrigger_scan_count_r};
			`ACGC_OFF_GP_VALUE:
				rdata_nxt = {16'h0000, general_count_bits_r};
			`ACGC_OFF_GP_CONTROL:
				rdata_nxt = 32'h00000000;
			`ACGC_OFF_UNUSED_A,
			`ACGC_OFF_UNUSED_B:
				rdata_nxt = 32'h00000000;
			default:
				rdata_nxt = 32'h00000000;
		endcase
	end

	always @(posedge core_clk)
	begin
		if (reset)
		begin
			reg_rdata  <= 32'h00000000;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rvalid <= rd_ok;
			if (rd_ok)
				reg_rdata <= rdata_nxt;
		end
	end

endmodule

`default_nettype wire

// File: verification/acgc_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Register port and counter output checks
// ---------------------------------------------------------------
module acgc_top_monitor
(
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        reset,
	// Register port
	input wire logic [7:0]  reg_addr,
	input wire logic [3:0]  reg_be,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic        reg_rvalid,
	// Sequencer side
	input wire logic        delay_trigger_mode,
	input wire logic        pre_mid_trigger_mode,
	input wire logic [23:0] scan_interval_value,
	input wire logic [15:0] sample_interval_value,
	input wire logic [15:0] trigger_delay_value,
	input wire logic [15:0] pretrigger_scan_value,
	// Counter pin
	input wire logic        counter_output_pin
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);
	wire logic        rd_ok = reg_rd && reg_be == 4'hf;
	wire logic        wr_ok = reg_wr && reg_be == 4'hf;
	wire logic [23:0] wd24  = reg_wdata[23:0];
	wire logic [15:0] wd16  = reg_wdata[15:0];
	wire logic        hole  = reg_addr == 8'h1c || reg_addr == 8'h2c;

	a_read_answered: assert property (rd_ok |=> reg_rvalid)
		else $error("full word read not answered");
	a_rvalid_cause: assert property (reg_rvalid |-> $past(rd_ok))
		else $error("read answer without full word read");
	a_hole_zero: assert property (rd_ok && hole |=> reg_rdata == 32'h0)
		else $error("unused offset read not zero");
	a_ctrl_zero: assert property
		(rd_ok && reg_addr == 8'h20 |=> reg_rdata == 32'h0)
		else $error("control offset read not zero");
	a_scan_load: assert property
		(wr_ok && reg_addr == 8'h00 |=> scan_interval_value == $past(wd24))
		else $error("scan interval not loaded");
	a_sample_load: assert property
		(wr_ok && reg_addr == 8'h04 |=> sample_interval_value == $past(wd16))
		else $error("sample interval not loaded");
	a_scan_holds: assert property
		(!(wr_ok && reg_addr == 8'h00) |=> $stable(scan_interval_value))
		else $error("scan interval changed without write");
	a_delay_gated: assert property
		(!delay_trigger_mode |-> trigger_delay_value == 16'h0)
		else $error("delay value seen outside delay mode");
	a_pretrig_gated: assert property
		(!pre_mid_trigger_mode |-> pretrigger_scan_value == 16'h0)
		else $error("pretrigger value seen outside its modes");
	a_out_single: assert property
		(counter_output_pin |=> !counter_output_pin)
		else $error("counter output longer than one cycle");
endmodule

bind acgc_top acgc_top_monitor mon (.core_clk(core_clk), .reset(reset),
	.reg_addr(reg_addr), .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.delay_trigger_mode(delay_trigger_mode),
	.pre_mid_trigger_mode(pre_mid_trigger_mode),
	.scan_interval_value(scan_interval_value),
	.sample_interval_value(sample_interval_value),
	.trigger_delay_value(trigger_delay_value),
	.pretrigger_scan_value(pretrigger_scan_value),
	.counter_output_pin(counter_output_pin));
`default_nettype wire

// File: verification/acgc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Outside party on the counter pins
// ---------------------------------------------------------------
// Each pin level is held four core cycles, slower than the filter needs.
module acgc_pin_model
(
	input wire logic core_clk,
	output var logic ext_clk,
	output var logic ext_gate,
	output var logic ext_dir
);
	initial
	begin
		ext_clk = 1'b0;
		ext_gate = 1'b0;
		ext_dir = 1'b0;
	end
	task burst(input int n);
		repeat (n)
		begin
			repeat (4) @(negedge core_clk);
			ext_clk = 1'b1;
			repeat (4) @(negedge core_clk);
			ext_clk = 1'b0;
		end
	endtask
	task set_lines(input logic g, input logic up);
		@(negedge core_clk);
		ext_gate = g;
		ext_dir = up;
		// Lets the core's filter take the new levels before use.
		repeat (4) @(negedge core_clk);
	endtask
endmodule
`default_nettype wire

// File: verification/tb_acq_and_gp_counter_block.sv
`timescale 1ns/1ps
`default_nettype none
module tb_acq_and_gp_counter_block;
	logic        core_clk, reset, reg_wr, reg_rd, dly_m, pre_m;
	logic        reg_rvalid, out_pin, ext_clk, ext_gate, ext_dir;
	logic [7:0]  reg_addr;
	logic [3:0]  reg_be;
	logic [31:0] reg_wdata, reg_rdata;
	logic [15:0] dly_v, pre_v, smp_v;
	logic [23:0] scan_v, tot_v;
	logic [8:0]  spc_v;
	int          n_mismatch, comparisons, pulses;
	logic [7:0]  offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
	logic [31:0] msk [6] = '{32'hffffff, 32'hffff, 32'hffffff, 32'h1ff,
		32'hffff, 32'hffff};

	acgc_top #(.TIMEBASE_DIV(2)) uut (.core_clk(core_clk), .reset(reset),
		.reg_addr(reg_addr), .reg_be(reg_be), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .delay_trigger_mode(dly_m),
		.pre_mid_trigger_mode(pre_m), .scan_interval_value(scan_v),
		.sample_interval_value(smp_v), .total_scan_value(tot_v),
		.samples_per_scan_value(spc_v), .trigger_delay_value(dly_v),
		.pretrigger_scan_value(pre_v),
		.ext_counter_clock_pin(ext_clk), .ext_counter_gate_pin(ext_gate),
		.ext_counter_direction_pin(ext_dir), .counter_output_pin(out_pin));
	acgc_pin_model pins (.core_clk(core_clk), .ext_clk(ext_clk),
		.ext_gate(ext_gate), .ext_dir(ext_dir));

	always #5 core_clk = ~core_clk;
	always @(posedge core_clk)
		if (out_pin === 1'b1)
			pulses <= pulses + 1;

	task check(input string nm, input logic [31:0] exp, got);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be = 4'hf);
		@(negedge core_clk);
		reg_addr = a;
		reg_be = be;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		@(negedge core_clk);
		reg_addr = a;
		reg_be = 4'hf;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		check("rvalid", 32'h1, {31'h0, reg_rvalid});
		check($sformatf("rdata at %h", a), exp, reg_rdata);
	endtask
	// Runs the counter enabled for n+2 core cycles, then stops it.
	task run(input logic [7:0] ctl, input int n);
		wr(8'h20, {24'h0, ctl});
		repeat (n) @(negedge core_clk);
		wr(8'h20, 32'h0);
	endtask
	task wrap_up;
		if (n_mismatch == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		#200000;
		n_mismatch++;
		wrap_up;
	end

	initial
	begin
		{core_clk, reg_wr, reg_rd, dly_m, pre_m} = 5'h0;
		{reg_addr, reg_be, reg_wdata} = 44'h0;
		{n_mismatch, comparisons} = '0;
		reset = 1'b1;
		repeat (4) @(negedge core_clk);
		reset = 1'b0;
		for (int i = 0; i < 6; i++)
		begin
			rd(offs[i], 32'h0);
			wr(offs[i], 32'hffffff5a + i);
			rd(offs[i], (32'hffffff5a + i) & msk[i]);
		end
		check("delay off", 32'h0, 32'(dly_v));
		check("pretrig off", 32'h0, 32'(pre_v));
		check("scan out", 32'hffff5a, 32'(scan_v));
		check("sample out", 32'hff5b, 32'(smp_v));
		check("total out", 32'hffff5c, 32'(tot_v));
		check("per scan out", 32'h15d, 32'(spc_v));
		{dly_m, pre_m} = 2'h3;
		@(negedge core_clk);
		check("delay out", 32'hff5e, 32'(dly_v));
		check("pretrig out", 32'hff5f, 32'(pre_v));
		wr(8'h1c, 32'hffffffff);
		wr(8'h2c, 32'hffffffff);
		rd(8'h1c, 32'h0);
		rd(8'h2c, 32'h0);
		wr(8'h00, 32'h0, 4'h3);
		rd(8'h00, 32'hffff5a);
		wr(8'h18, 32'h5);
		rd(8'h18, 32'h5);
		run(8'hc0, 18);
		rd(8'h18, 32'hf);
		rd(8'h20, 32'h0);
		run(8'h80, 8);
		rd(8'h18, 32'ha);
		run(8'h82, 8);
		rd(8'h18, 32'ha);
		pins.set_lines(1'b0, 1'b1);
		run(8'h90, 8);
		rd(8'h18, 32'ha);
		pins.set_lines(1'b1, 1'b1);
		run(8'hb0, 8);
		rd(8'h18, 32'hf);
		pins.set_lines(1'b1, 1'b0);
		run(8'ha0, 8);
		rd(8'h18, 32'ha);
		wr(8'h20, 32'h88);
		pins.burst(3);
		wr(8'h20, 32'h0);
		rd(8'h18, 32'h7);
		wr(8'h18, 32'h2);
		run(8'h80, 2);
		rd(8'h18, 32'h0);
		check("event pulse", 32'h1, 32'(pulses));
		wr(8'h18, 32'h2);
		run(8'h81, 28);
		rd(8'h18, 32'h2);
		check("pulses", 32'h6, 32'(pulses));
		wrap_up;
	end
endmodule
`default_nettype wire
